/* File: sim/rsc_src_model.sv */
// Behavioural model of the reset detectors, pin, watchdog and scan chain
`timescale 1ns/10ps
module rsc_src_model (
    input wire rsc_pkg::rsc_src_t want, // Requested source levels
    output logic power_low,             // Power-on detector output
    output logic ext_reset_n,           // Reset pin, low when asserted
    output logic wdt_expire,            // Watchdog expiry, high on timeout
    output logic supply_brownout,       // Brown-out detector output
    output logic scan_reset_bit         // Scan-chain reset register bit
);
    // ------------------------------------------------------------
    // Levels follow the request at once; bench changes it after an edge
    // ------------------------------------------------------------
    assign power_low = want.por;
    assign ext_reset_n = ~want.ext;     // Pin held low as long as asked
    assign wdt_expire = want.wdt;
    assign supply_brownout = want.bod;
    assign scan_reset_bit = want.scan;
endmodule : rsc_src_model

/* File: sim/rsc_top_assertions.sv */
// Concurrent checks on the reset combiner ports
`timescale 1ns/10ps
module rsc_top_assertions #(
    parameter int STARTUP_SHORT = 20, // Short stretch cycles
    parameter int STARTUP_LONG = 40,  // Long stretch cycles
    parameter int EXT_MIN = 4         // Pin filter cycles
) (
    input wire logic mclk,               // System clock
    input wire logic nrst,               // Reset, active low
    input wire logic power_low,          // Power-on detector
    input wire logic ext_reset_n,        // Reset pin
    input wire logic wdt_expire,         // Watchdog expiry
    input wire logic supply_brownout,    // Brown-out detector
    input wire logic scan_reset_bit,     // Scan reset bit
    input wire logic io_port_reset,      // I/O reset
    input wire logic core_reset,         // Stretched reset
    input wire logic fetch_reset_vector  // Restart pulse
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    localparam int LIM = STARTUP_LONG + EXT_MIN + 16; // Saturation keeps counters small
    int quiet_q; // Cycles since any raw source was high
    int low_q;   // Consecutive low cycles of the pin
    logic any_src;
    assign any_src = power_low | ~ext_reset_n | wdt_expire | supply_brownout | scan_reset_bit;

    // Quiet time, conservative: disabled sources also restart it
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            quiet_q <= 0;
        end else if (any_src) begin
            quiet_q <= 0;
        end else if (quiet_q < LIM) begin
            quiet_q <= quiet_q + 1;
        end
    end

    // Pin low run length
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            low_q <= 0;
        end else if (ext_reset_n) begin
            low_q <= 0;
        end else if (low_q < LIM) begin
            low_q <= low_q + 1;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_pwr_low;
        power_low [*2];
    endsequence
    sequence s_scan_hi;
        scan_reset_bit [*2];
    endsequence

    property p_io_por;
        s_pwr_low |-> io_port_reset;
    endproperty
    property p_io_scan;
        s_scan_hi |-> io_port_reset;
    endproperty
    property p_core_por;
        s_pwr_low |=> core_reset;
    endproperty
    property p_core_scan;
        s_scan_hi |=> core_reset;
    endproperty
    property p_ext_long;
        (low_q == EXT_MIN + 2) |=> core_reset;
    endproperty
    property p_stretch_min;
        $fell(core_reset) |-> (quiet_q >= STARTUP_SHORT - 4);
    endproperty
    property p_stretch_max;
        (quiet_q == STARTUP_LONG + EXT_MIN + 8) |-> !core_reset;
    endproperty
    property p_fetch_fall;
        $fell(core_reset) |-> fetch_reset_vector;
    endproperty
    property p_fetch_one;
        fetch_reset_vector |=> !fetch_reset_vector;
    endproperty

    a_io_por: assert property (p_io_por) else $error("io reset missing at power low");
    a_io_scan: assert property (p_io_scan) else $error("io reset missing on scan");
    a_core_por: assert property (p_core_por) else $error("core not held at power low");
    a_core_scan: assert property (p_core_scan) else $error("core not held on scan");
    a_ext_long: assert property (p_ext_long) else $error("long pin low gave no reset");
    a_stretch_min: assert property (p_stretch_min) else $error("stretch too short");
    a_stretch_max: assert property (p_stretch_max) else $error("stretch too long");
    a_fetch_fall: assert property (p_fetch_fall) else $error("no restart at release");
    a_fetch_one: assert property (p_fetch_one) else $error("restart pulse too long");
endmodule : rsc_top_assertions

bind rsc_top rsc_top_assertions #(
    .STARTUP_SHORT(STARTUP_SHORT),
    .STARTUP_LONG(STARTUP_LONG),
    .EXT_MIN(EXT_MIN)
) u_chk (.mclk(mclk), .nrst(nrst), .power_low(power_low), .ext_reset_n(ext_reset_n),
    .wdt_expire(wdt_expire), .supply_brownout(supply_brownout),
    .scan_reset_bit(scan_reset_bit), .io_port_reset(io_port_reset),
    .core_reset(core_reset), .fetch_reset_vector(fetch_reset_vector));

/* File: sim/tb.sv */
// Self-checking testbench of the reset source combiner
`timescale 1ns/10ps
module tb;
    localparam int SH = 20; // Short stretch, kept small for run time
    localparam int LG = 40; // Long stretch
    localparam int EM = 4;  // Pin filter
    logic mclk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [3:0] fuses = 4'h1; // Long start-up first
    logic hreadyout, hresp, io_port_reset, core_reset, fetch_reset_vector, irq;
    logic power_low, ext_reset_n, wdt_expire, supply_brownout, scan_reset_bit;
    logic en, bod;
    rsc_pkg::rsc_src_t want = '0;
    int n_fail = 0, checked = 0, cyc = 0, n;
    assign hready = hreadyout; // Single slave drives bus ready

    rsc_top #(.STARTUP_SHORT(SH), .STARTUP_LONG(LG), .EXT_MIN(EM)) uut (.mclk(mclk),
        .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .power_low(power_low), .ext_reset_n(ext_reset_n),
        .wdt_expire(wdt_expire), .supply_brownout(supply_brownout),
        .scan_reset_bit(scan_reset_bit), .clock_select_fuses(fuses),
        .io_port_reset(io_port_reset), .core_reset(core_reset),
        .fetch_reset_vector(fetch_reset_vector), .irq(irq));
    rsc_src_model u_src (.want(want), .power_low(power_low), .ext_reset_n(ext_reset_n),
        .wdt_expire(wdt_expire), .supply_brownout(supply_brownout),
        .scan_reset_bit(scan_reset_bit));

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial begin
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task report_and_stop();
        if (n_fail == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word
    task chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit
    // One AHB single word transfer; the next call leaves one idle cycle
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask : xfer
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk_word(rd, exp);
    endtask : rdc
    task set_src(input rsc_pkg::rsc_src_t v);
        @(posedge mclk);
        want <= v;
    endtask : set_src
    // Counts edges until the stretched reset lifts, bounded
    task wait_core(output int k);
        k = 0;
        while (core_reset !== 1'b0 && k < 300) begin
            @(negedge mclk);
            k++;
        end
    endtask : wait_core

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        wait_core(n);
        chk_bit(n >= LG && n <= LG + 6, 1'b1);
        rdc(rsc_pkg::OFF_CAUSE, 32'h0);
        rdc(rsc_pkg::OFF_CTRL, 32'h0);
        rdc(rsc_pkg::OFF_INT_MASK, 32'h0);
        rdc(8'h14, 32'h0);
        chk_bit(hresp, 1'b0);
        // Power-on: ports and core held three cycles later, flag bit 0
        set_src('{por: 1'b1, default: 1'b0});
        repeat (3) @(negedge mclk);
        chk_bit(io_port_reset, 1'b1);
        chk_bit(core_reset, 1'b1);
        set_src('0);
        wait_core(n);
        chk_bit(n >= LG - 2 && n <= LG + 6, 1'b1);
        rdc(rsc_pkg::OFF_CAUSE, 32'h1);
        xfer(rsc_pkg::OFF_CAUSE, 1'b1, 32'hffffffff);
        rdc(rsc_pkg::OFF_CAUSE, 32'h1);
        xfer(rsc_pkg::OFF_CAUSE, 1'b1, 32'h0);
        rdc(rsc_pkg::OFF_CAUSE, 32'h0);
        rdc(rsc_pkg::OFF_INT_STAT, 32'h1);
        rdc(rsc_pkg::OFF_INT_STAT, 32'h0);
        // Pin: too short is filtered, long resets and raises the masked interrupt
        set_src('{ext: 1'b1, default: 1'b0});
        set_src('0);
        repeat (EM + 2) @(negedge mclk);
        chk_bit(core_reset, 1'b0);
        xfer(rsc_pkg::OFF_INT_STAT, 1'b0, 32'h0); // Discard whatever the glitch left
        xfer(rsc_pkg::OFF_INT_MASK, 1'b1, 32'h2);
        @(posedge mclk);
        fuses <= 4'h0; // Short start-up from here on
        set_src('{ext: 1'b1, default: 1'b0});
        repeat (EM + 4) @(negedge mclk);
        chk_bit(core_reset, 1'b1);
        chk_bit(irq, 1'b1);
        set_src('0);
        wait_core(n);
        chk_bit(n >= SH - 2 && n <= SH + 6, 1'b1);
        rdc(rsc_pkg::OFF_CAUSE, 32'h2);
        rdc(rsc_pkg::OFF_INT_STAT, 32'h2);
        repeat (2) @(negedge mclk);
        chk_bit(irq, 1'b0);
        // Watchdog and brown-out, each disabled then enabled
        for (int s = 0; s < 4; s++) begin
            en = s[0];
            bod = s[1];
            xfer(rsc_pkg::OFF_CAUSE, 1'b1, 32'h0);
            xfer(rsc_pkg::OFF_CTRL, 1'b1, {30'h0, bod & en, ~bod & en});
            set_src({1'b0, ~bod, bod, 2'b00});
            @(negedge mclk);
            if (bod) chk_bit(io_port_reset, en);
            repeat (2) @(posedge mclk);
            set_src('0);
            repeat (2) @(negedge mclk);
            chk_bit(core_reset, en);
            wait_core(n);
            rdc(rsc_pkg::OFF_CAUSE, {28'h0, ~bod & en, bod & en, 2'h0});
        end
        // Scan chain holds reset beyond any stretch
        xfer(rsc_pkg::OFF_CAUSE, 1'b1, 32'h0);
        set_src('{scan: 1'b1, default: 1'b0});
        @(negedge mclk);
        chk_bit(io_port_reset, 1'b1);
        repeat (LG + 10) @(negedge mclk);
        chk_bit(core_reset, 1'b1);
        rdc(rsc_pkg::OFF_STATE, 32'h7);
        set_src('0);
        wait_core(n);
        rdc(rsc_pkg::OFF_CAUSE, 32'h10);
        // Power-on clears the scan flag and sets its own
        set_src('{por: 1'b1, default: 1'b0});
        repeat (3) @(posedge mclk);
        set_src('0);
        wait_core(n);
        rdc(rsc_pkg::OFF_CAUSE, 32'h1);
        report_and_stop();
    end
endmodule : tb

/* File: src/rsc_pkg.sv */
// Package of constants and types for the reset source combiner
package rsc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CAUSE = 8'h00;   // Reset cause flags
    localparam logic [7:0] OFF_CTRL = 8'h04;    // Detector enables
    localparam logic [7:0] OFF_INT_STAT = 8'h08; // Sticky events, read clears
    localparam logic [7:0] OFF_INT_MASK = 8'h0c; // Interrupt mask
    localparam logic [7:0] OFF_STATE = 8'h10;   // Live reset state

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_POR = 0;     // Power-on flag
    localparam int BIT_EXT = 1;     // External pin flag
    localparam int BIT_BOD = 2;     // Brown-out flag
    localparam int BIT_WDT = 3;     // Watchdog flag
    localparam int BIT_SCAN = 4;    // Scan-chain flag
    localparam int NUM_SRC = 5;     // Number of reset sources
    localparam int BIT_WDT_EN = 0;  // Control: watchdog enable
    localparam int BIT_BOD_EN = 1;  // Control: brown-out enable

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [4:0] CAUSE_RST = 5'h00;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [4:0] MASK_RST = 5'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;                 // mclk rate
    localparam int EXT_MIN_PULSE_NS = 1500;       // Least pin pulse
    localparam int EXT_MIN_CYC = (EXT_MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int STARTUP_SHORT_US = 4100;       // Short start-up time
    localparam int STARTUP_LONG_US = 65000;       // Long start-up time
    localparam int STARTUP_SHORT_CYC = STARTUP_SHORT_US * CLK_MHZ;
    localparam int STARTUP_LONG_CYC = STARTUP_LONG_US * CLK_MHZ;
    localparam int CNT_W = 24;                    // Stretch counter width

    // ------------------------------------------------------------
    // Bus and source carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;        // Transfer pending in data phase
        logic write;        // Direction
        logic [7:0] addr;   // Low byte of the address
    } rsc_aphase_t;

    typedef struct packed {
        logic scan;         // Scan-chain reset
        logic wdt;          // Watchdog pulse
        logic bod;          // Qualified brown-out
        logic ext;          // Filtered pin reset
        logic por;          // Power-on
    } rsc_src_t;

endpackage : rsc_pkg

/* File: src/rsc_top.sv */
// Reset source combiner with cause flags and AHB-Lite register slave
//
// How it works
// - Reset clears I/O state, restarts at vector
// - I/O ports reset instantly on power-on, scan or brown-out, needing no clock; pin and watchdog wait for a clock edge
// - Stretch internal reset by fuse-selected delay
// - Five reset sources, any one resets
// - Hold reset while supply below power-on threshold
// - Low pin longer than minimum pulse resets
// - Watchdog expiry resets only when enabled
// - Brown-out resets only when detector enabled
// - Scan-chain reset bit holds reset
// - Watchdog reset pulse lasts one clock
// - Delay starts at watchdog pulse falling edge
// - Bit 4 scan flag, cleared by POR/zero
// - Bit 3 watchdog flag, cleared by POR/zero
// - Bit 2 brown-out flag, cleared by POR/zero
// - Bit 1 pin flag, cleared by POR/zero
// - Bit 0 power-on flag, cleared only by zero
`timescale 1ns/10ps
module rsc_top #(
    parameter int STARTUP_SHORT = rsc_pkg::STARTUP_SHORT_CYC, // Short stretch cycles
    parameter int STARTUP_LONG = rsc_pkg::STARTUP_LONG_CYC,   // Long stretch cycles
    parameter int EXT_MIN = rsc_pkg::EXT_MIN_CYC              // Pin filter cycles
) (
    input wire logic mclk,                  // System clock, 125 MHz
    input wire logic nrst,                  // Bus reset, active low
    input wire logic hsel,                  // AHB select
    input wire logic [31:0] haddr,          // AHB address
    input wire logic [1:0] htrans,          // AHB transfer type
    input wire logic hwrite,                // AHB direction
    input wire logic [2:0] hsize,           // AHB size
    input wire logic [31:0] hwdata,         // AHB write data
    input wire logic hready,                // AHB bus ready
    output logic hreadyout,                 // AHB slave ready
    output logic [31:0] hrdata,             // AHB read data
    output logic hresp,                     // AHB response
    input wire logic power_low,             // Supply below power-on threshold
    input wire logic ext_reset_n,           // External reset pin
    input wire logic wdt_expire,            // Watchdog period expired
    input wire logic supply_brownout,       // Supply below brown-out threshold
    input wire logic scan_reset_bit,        // Scan-chain reset register bit
    input wire logic [3:0] clock_select_fuses, // Start-up time selection
    output logic io_port_reset,             // I/O ports held in reset
    output logic core_reset,                // Stretched internal reset
    output logic fetch_reset_vector,        // One-cycle restart pulse
    output logic irq                        // Interrupt, level
);

    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic rst_meta_q;   // First stage, read only by second
    logic rst_sync_q;   // Released reset used by the design

    // Release is synchronised; assertion stays asynchronous
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [4:0] cause_q;        // Reset cause flags
    logic [1:0] ctrl_q;         // Detector enables
    logic [4:0] int_stat_q;     // Sticky events
    logic [4:0] int_mask_q;     // Event mask
    rsc_pkg::rsc_aphase_t aph_q; // Captured address phase
    rsc_pkg::rsc_src_t src;     // Qualified sources
    logic [4:0] src_vec;        // Sources as a vector
    logic [4:0] src_prev_q;     // Sources one cycle ago
    logic [4:0] src_rise;       // New source events

    // ------------------------------------------------------------
    // Source qualification
    // ------------------------------------------------------------
    logic [15:0] ext_cnt_q;     // Pin low duration
    logic ext_valid;            // Pin low long enough
    logic wdt_pulse_q;          // One-cycle watchdog reset
    logic wdt_prev_q;           // Previous expire level

    // Pin must stay low past the minimum pulse before it counts
    always_ff @(posedge mclk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ext_cnt_q <= 16'h0000;
        end else if (ext_reset_n) begin
            ext_cnt_q <= 16'h0000;
        end else if (ext_cnt_q != 16'(EXT_MIN)) begin
            ext_cnt_q <= ext_cnt_q + 16'h0001;
        end
    end

    assign ext_valid = (ext_cnt_q == 16'(EXT_MIN));

    // Expiry edge yields a single clock of reset, only if enabled
    always_ff @(posedge mclk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            wdt_prev_q <= 1'b0;
            wdt_pulse_q <= 1'b0;
        end else begin
            wdt_prev_q <= wdt_expire;
            wdt_pulse_q <= wdt_expire && !wdt_prev_q
                           && ctrl_q[rsc_pkg::BIT_WDT_EN];
        end
    end

    // Gather the five sources
    always_comb begin
        src.por = power_low;
        src.ext = ext_valid;
        src.wdt = wdt_pulse_q;
        src.bod = supply_brownout && ctrl_q[rsc_pkg::BIT_BOD_EN];
        src.scan = scan_reset_bit;
    end

    assign src_vec = src;

    // ------------------------------------------------------------
    // Reset stretching
    // ------------------------------------------------------------
    logic any_src;                      // OR of all sources
    logic [rsc_pkg::CNT_W-1:0] stretch_q; // Cycles since last release
    logic [rsc_pkg::CNT_W-1:0] stretch_end; // Selected time-out
    logic core_reset_q;                 // Internal reset level
    logic fetch_q;                      // Restart pulse
    logic io_hold_q;                    // I/O reset level
    logic async_src;                    // Level sources that need no clock

    assign any_src = |src_vec;

    // Fuse value picks short or long start-up time
    assign stretch_end = clock_select_fuses[0] ?
        rsc_pkg::CNT_W'(STARTUP_LONG) : rsc_pkg::CNT_W'(STARTUP_SHORT);

    // Count restarts while any source is active, so the delay begins only
    // when the last source releases (watchdog: at its pulse falling edge)
    always_ff @(posedge mclk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            stretch_q <= '0;
            core_reset_q <= 1'b1;
            fetch_q <= 1'b0;
        end else if (any_src) begin
            stretch_q <= '0;
            core_reset_q <= 1'b1;
            fetch_q <= 1'b0;
        end else if (core_reset_q) begin
            if (stretch_q >= stretch_end - 1'b1) begin
                core_reset_q <= 1'b0;
                fetch_q <= 1'b1;
            end else begin
                stretch_q <= stretch_q + 1'b1;
            end
        end else begin
            fetch_q <= 1'b0;
        end
    end

    // Supply and scan levels reach the I/O hold without a clock edge;
    // the flop is set asynchronously so a dead clock cannot delay it
    assign async_src = power_low || scan_reset_bit
                       || (supply_brownout && ctrl_q[rsc_pkg::BIT_BOD_EN]);

    always_ff @(posedge mclk or posedge async_src) begin
        if (async_src) begin
            io_hold_q <= 1'b1;
        end else begin
            io_hold_q <= any_src || core_reset_q;
        end
    end

    // ------------------------------------------------------------
    // Cause flags
    // ------------------------------------------------------------
    logic cause_wr;             // Write to the cause register
    logic [4:0] cause_keep;     // Written-zero bits clear, ones keep

    always_ff @(posedge mclk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            src_prev_q <= 5'h00;
        end else begin
            src_prev_q <= src_vec;
        end
    end

    assign src_rise = src_vec & ~src_prev_q;
    assign cause_wr = aph_q.valid && aph_q.write && (aph_q.addr == rsc_pkg::OFF_CAUSE);
    assign cause_keep = cause_wr ? hwdata[4:0] : 5'h1f;

    // Power-on clears the other flags; any set wins over a clear
    always_ff @(posedge mclk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            cause_q <= rsc_pkg::CAUSE_RST;
        end else begin
            cause_q[rsc_pkg::BIT_POR] <= src.por
                || (cause_q[rsc_pkg::BIT_POR] && cause_keep[rsc_pkg::BIT_POR]);
            cause_q[rsc_pkg::BIT_EXT] <= src.ext
                || (!src.por && cause_q[rsc_pkg::BIT_EXT]
                    && cause_keep[rsc_pkg::BIT_EXT]);
            cause_q[rsc_pkg::BIT_BOD] <= src.bod
                || (!src.por && cause_q[rsc_pkg::BIT_BOD]
                    && cause_keep[rsc_pkg::BIT_BOD]);
            cause_q[rsc_pkg::BIT_WDT] <= src.wdt
                || (!src.por && cause_q[rsc_pkg::BIT_WDT]
                    && cause_keep[rsc_pkg::BIT_WDT]);
            cause_q[rsc_pkg::BIT_SCAN] <= src.scan
                || (!src.por && cause_q[rsc_pkg::BIT_SCAN]
                    && cause_keep[rsc_pkg::BIT_SCAN]);
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    logic aph_take;             // Address phase accepted this edge
    logic [31:0] rd_mux;        // Read value selected by address
    logic int_rd;               // Read of interrupt status
    logic [31:0] hrdata_q;      // Registered read data
    logic hreadyout_q;          // Always ready after reset
    logic irq_q;                // Interrupt level

    assign aph_take = hsel && htrans[1] && hready;

    // Capture the address phase for the data phase that follows
    always_ff @(posedge mclk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            aph_q <= '0;
            hreadyout_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
            if (hready) begin
                aph_q.valid <= aph_take;
                aph_q.write <= hwrite;
                aph_q.addr <= haddr[7:0];
            end
        end
    end

    // Read data is chosen in the address phase so it comes from a flop;
    // unmapped words read zero and still answer OKAY
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            rsc_pkg::OFF_CAUSE: rd_mux[4:0] = cause_q;
            rsc_pkg::OFF_CTRL: rd_mux[1:0] = ctrl_q;
            rsc_pkg::OFF_INT_STAT: rd_mux[4:0] = int_stat_q;
            rsc_pkg::OFF_INT_MASK: rd_mux[4:0] = int_mask_q;
            rsc_pkg::OFF_STATE: rd_mux[2:0] = {any_src, io_hold_q, core_reset_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            hrdata_q <= 32'h0000_0000;
        end else if (aph_take && !hwrite) begin
            hrdata_q <= rd_mux;
        end
    end

    assign int_rd = aph_take && !hwrite && (haddr[7:0] == rsc_pkg::OFF_INT_STAT);

    // Control and mask writes in the data phase
    always_ff @(posedge mclk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ctrl_q <= rsc_pkg::CTRL_RST;
            int_mask_q <= rsc_pkg::MASK_RST;
        end else if (aph_q.valid && aph_q.write) begin
            if (aph_q.addr == rsc_pkg::OFF_CTRL) begin
                ctrl_q <= hwdata[1:0];
            end
            if (aph_q.addr == rsc_pkg::OFF_INT_MASK) begin
                int_mask_q <= hwdata[4:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // Each new source sets a sticky bit; a read clears, new events win
    always_ff @(posedge mclk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            int_stat_q <= 5'h00;
        end else if (int_rd) begin
            int_stat_q <= src_rise;
        end else begin
            int_stat_q <= int_stat_q | src_rise;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(int_stat_q & int_mask_q);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hreadyout = hreadyout_q;
    assign hrdata = hrdata_q;
    assign hresp = 1'b0;
    assign io_port_reset = io_hold_q;
    assign core_reset = core_reset_q;
    assign fetch_reset_vector = fetch_q;
    assign irq = irq_q;

endmodule : rsc_top
